// ==== hdl/etpu_pkg.sv ====
// package for the edge timing pulse unit: register map, fields, reset values, encodings
package etpu_pkg;

	// register byte addresses on the wishbone slave
	localparam logic [3:0] ETPU_ADDR_REFCTL = 4'h0;
	localparam logic [3:0] ETPU_ADDR_EDGCTL = 4'h4;

	localparam logic [15:0] ETPU_REFCTL_RESET = 16'h0000;
	localparam logic [15:0] ETPU_EDGCTL_RESET = 16'h0000;

	// reference control fields
	localparam int ETPU_REF_ON = 7;
	localparam int ETPU_REF_PIN = 6;
	localparam int ETPU_REF_RANGE = 5;
	localparam int ETPU_REF_SRC = 4;
	localparam int ETPU_REF_CODE_LSB = 0;
	localparam logic [15:0] ETPU_REFCTL_MASK = 16'h00FF;

	// edge timing control fields
	localparam int ETPU_UNIT_EN = 15;
	localparam int ETPU_IDLE_STOP = 13;
	localparam int ETPU_DLY_EN = 12;
	localparam int ETPU_EDGE_PASS = 11;
	localparam int ETPU_ORDER = 10;
	localparam int ETPU_IGND = 9;
	localparam int ETPU_TRIG = 8;
	localparam int ETPU_E2_POL = 7;
	localparam int ETPU_E2_SEL_LSB = 5;
	localparam int ETPU_E1_POL = 4;
	localparam int ETPU_E1_SEL_LSB = 2;
	localparam int ETPU_E2_SEEN = 1;
	localparam int ETPU_E1_SEEN = 0;
	localparam logic [15:0] ETPU_EDGCTL_MASK = 16'hBFFF;

	// edge source encoding
	typedef enum logic [1:0] {
		ETPU_SRC_TIMER = 2'b00,
		ETPU_SRC_OCMP = 2'b01,
		ETPU_SRC_PIN2 = 2'b10,
		ETPU_SRC_PIN1 = 2'b11
	} etpu_src_t;

	// reference setting handed to the analog ladder
	typedef struct packed {
		logic genOn;
		logic pinDrive;
		logic rangeSelect;
		logic spanSource;
		logic [3:0] levelCode;
	} etpu_ref_t;

	// edge inputs, all asynchronous to clk
	typedef struct packed {
		logic pinOne;
		logic pinTwo;
		logic outputCompareOne;
		logic timerOne;
	} etpu_edges_t;

	// analog switch controls
	typedef struct packed {
		logic currentToCompB;
		logic refToCompA;
		logic currentGround;
		logic measurePulse;
	} etpu_analog_t;

endpackage : etpu_pkg

// ==== hdl/etpu_unit.sv ====
// edge timing pulse unit control logic with wishbone register slave
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps

// Behaviour
// [R01] reference-enable bit 7 powers the reference generator; resets to off
// [R02] reference pin-drive bit 6 connects the reference level to its pin
// [R03] range bit 5: level code/24 of span, else span/4 plus code/32
// [R04] source bit 4 picks external reference pins, else analog supply rails
// [R05] 4-bit level code in bits 3-0; upper byte reads zero
// [R06] unit-enable bit 15 activates the edge timing unit
// [R07] idle-stop bit 13 halts the unit while device is idle
// [R08] delay-generation bit 12 turns on delayed pulse generation
// [R09] delay mode routes current to comparator B, reference to comparator A
// [R10] delay mode charges on edge, pulses output when comparator trips
// [R11] measurement pulse spans time between the two selected edge events
// [R12] edge-pass bit lets edges through; clear blocks all edges
// [R13] order bit accepts edge 2 only after edge 1; code also accepts edge 2 in the same cycle as an accepted edge 1
// [R14] ground bit 9 grounds the current source output
// [R15] trigger bit 8 enables trigger output to other peripherals
// [R16] edge-2 polarity bit: rising when set, falling when clear
// [R17] edge-2 source: 11 pin one, 10 pin two, 01 compare, 00 timer
// [R18] edge-1 polarity bit: rising when set, falling when clear
// [R19] edge-1 source in bits 3-2, same encoding as edge 2
// [R20] status bit 0 edge-1 seen, bit 1 edge-2 seen; software writable
// [R21] status set by first accepted edge, held until software clears it
// [R22] disabled or blocked: ignore edges, keep status, pulse output inactive
module etpu_unit (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic deviceIdle,
	input wire etpu_pkg::etpu_edges_t edgesIn,
	input wire logic compTwoOut,
	output etpu_pkg::etpu_ref_t refSetting,
	output etpu_pkg::etpu_analog_t analogCtl,
	output logic delayedPulsePin,
	output logic triggerOut
);
	import etpu_pkg::*;

	logic [15:0] refCtl;
	logic [15:0] edgCtl;
	logic [3:0] edgeSync1;
	logic [3:0] edgeSync2;
	logic [3:0] edgePrev;
	logic compSync1;
	logic compSync2;
	logic reqHit;
	logic adrRef;
	logic adrEdg;
	logic active;
	logic rise1;
	logic rise2;
	logic e1Level;
	logic e1Last;
	logic e2Level;
	logic e2Last;
	logic e1Hit;
	logic e2Hit;
	logic e1Accept;
	logic e2Accept;
	logic [15:0] wrData;
	logic [15:0] wrMask;
	logic wrEdg;
	logic next_e1Seen;
	logic next_e2Seen;
	logic charging;
	logic [15:2] edgFields;
	logic e1Seen;
	logic e2Seen;
	logic rdHit;
	logic [15:0] rdData;
	logic delayMode;

	assign reqHit = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign adrRef = (wb_adr_i == ETPU_ADDR_REFCTL);
	assign adrEdg = (wb_adr_i == ETPU_ADDR_EDGCTL);
	assign wrMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// single wait-free answer; unmapped addresses get err instead of ack
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wb_ack_o <= 1'b0;
		end
		else
		begin
			wb_ack_o <= reqHit && (adrRef || adrEdg);
		end
	end

	// an unmapped access still ends the cycle, so a stray address cannot hang the master
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wb_err_o <= 1'b0;
		end
		else
		begin
			wb_err_o <= reqHit && !(adrRef || adrEdg);
		end
	end

	// read mux; unmapped addresses read zero
	always_comb
	begin
		rdData = 16'h0000;
		if (adrRef)
		begin
			rdData = refCtl & ETPU_REFCTL_MASK; // [R05]
		end
		else if (adrEdg)
		begin
			rdData = edgCtl & ETPU_EDGCTL_MASK;
		end
	end

	assign rdHit = reqHit && !wb_we_i;

	// read data stands with ack for one cycle; writes and idle cycles return zero
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wb_dat_o <= 32'h0000_0000;
		end
		else if (rdHit)
		begin
			wb_dat_o <= {16'h0000, rdData};
		end
		else
		begin
			wb_dat_o <= 32'h0000_0000;
		end
	end

	// writes take effect at the edge the ack rises
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			refCtl <= ETPU_REFCTL_RESET; // [R01]
		else if (reqHit && wb_we_i && adrRef)
			refCtl <= ((refCtl & ~wrMask) | (wb_dat_i[15:0] & wrMask)) & ETPU_REFCTL_MASK; // [R05]
	end

	assign wrEdg = reqHit && wb_we_i && adrEdg;
	assign wrData = ((edgCtl & ~wrMask) | (wb_dat_i[15:0] & wrMask)) & ETPU_EDGCTL_MASK;

	// two-flop synchronisers per edge source; the first stage is never looked at, detection compares the second stage with edgePrev
	for (genvar gi = 0; gi < 4; gi++)
	begin : g_edgeSync
		always_ff @(posedge clk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				edgeSync1[gi] <= 1'b0;
				edgeSync2[gi] <= 1'b0;
				edgePrev[gi] <= 1'b0;
			end
			else
			begin
				edgeSync1[gi] <= edgesIn[gi];
				edgeSync2[gi] <= edgeSync1[gi];
				edgePrev[gi] <= edgeSync2[gi];
			end
		end
	end

	// comparator trip is asynchronous too; costs two cycles of pulse delay
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			compSync1 <= 1'b0;
			compSync2 <= 1'b0;
		end
		else
		begin
			compSync1 <= compTwoOut;
			compSync2 <= compSync1;
		end
	end

	// struct order: pinOne[3], pinTwo[2], outputCompareOne[1], timerOne[0]
	function automatic logic pickSource(input logic [3:0] lv, input logic [1:0] sel);
		logic r;
		r = 1'b0;
		unique case (etpu_src_t'(sel))
			ETPU_SRC_PIN1: r = lv[3];
			ETPU_SRC_PIN2: r = lv[2];
			ETPU_SRC_OCMP: r = lv[1];
			ETPU_SRC_TIMER: r = lv[0];
		endcase
		return r;
	endfunction : pickSource

	// [R17] [R19] source selection on current and previous sample
	assign e1Level = pickSource(edgeSync2, edgCtl[ETPU_E1_SEL_LSB +: 2]);
	assign e1Last = pickSource(edgePrev, edgCtl[ETPU_E1_SEL_LSB +: 2]);
	assign e2Level = pickSource(edgeSync2, edgCtl[ETPU_E2_SEL_LSB +: 2]);
	assign e2Last = pickSource(edgePrev, edgCtl[ETPU_E2_SEL_LSB +: 2]);

	assign rise1 = edgCtl[ETPU_E1_POL];
	assign rise2 = edgCtl[ETPU_E2_POL];
	// polarity: rising when set, falling when clear
	assign e1Hit = rise1 ? (e1Level && !e1Last) : (!e1Level && e1Last); // [R18]
	assign e2Hit = rise2 ? (e2Level && !e2Last) : (!e2Level && e2Last); // [R16]

	// idle-stop freezes the unit without touching register contents
	assign active = edgCtl[ETPU_UNIT_EN] && !(edgCtl[ETPU_IDLE_STOP] && deviceIdle); // [R06] [R07]

	assign e1Accept = active && edgCtl[ETPU_EDGE_PASS] && e1Hit; // [R12] [R22]
	// edge 2 in order mode needs edge 1 already seen or arriving now
	assign e2Accept = active && edgCtl[ETPU_EDGE_PASS] && e2Hit
		&& (!edgCtl[ETPU_ORDER] || edgCtl[ETPU_E1_SEEN] || e1Accept); // [R13]

	// hardware set wins over a software clear in the same cycle
	always_comb
	begin
		next_e1Seen = wrEdg ? wrData[ETPU_E1_SEEN] : e1Seen;
		next_e2Seen = wrEdg ? wrData[ETPU_E2_SEEN] : e2Seen;
		if (e1Accept)
		begin
			next_e1Seen = 1'b1; // [R21]
		end
		if (e2Accept)
		begin
			next_e2Seen = 1'b1; // [R21]
		end
	end

	// control fields change only by software
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			edgFields <= ETPU_EDGCTL_RESET[15:2];
		end
		else if (wrEdg)
		begin
			edgFields <= wrData[15:2];
		end
	end

	// edge-1 flag: set by hardware, written either way by software
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			e1Seen <= ETPU_EDGCTL_RESET[ETPU_E1_SEEN];
		end
		else
		begin
			e1Seen <= next_e1Seen; // [R20]
		end
	end

	// edge-2 flag kept apart so clearing one never disturbs the other
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			e2Seen <= ETPU_EDGCTL_RESET[ETPU_E2_SEEN];
		end
		else
		begin
			e2Seen <= next_e2Seen; // [R20]
		end
	end

	assign edgCtl = {edgFields, e2Seen, e1Seen};

	// delay mode: charging runs from an accepted edge until the comparator trips
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			charging <= 1'b0;
		else if (!active || !edgCtl[ETPU_DLY_EN] || !edgCtl[ETPU_EDGE_PASS])
			charging <= 1'b0; // [R22]
		else if (charging && compSync2)
			charging <= 1'b0;
		else if (e1Accept || e2Accept)
			charging <= 1'b1; // [R10]
	end

	// pulse output; registered, one cycle after the synchronised trip
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			delayedPulsePin <= 1'b0;
		else
			delayedPulsePin <= active && edgCtl[ETPU_DLY_EN] && edgCtl[ETPU_EDGE_PASS]
				&& charging && compSync2; // [R10] [R22]
	end

	assign delayMode = active && edgCtl[ETPU_DLY_EN];

	// current steered into comparator B only while delay mode runs
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			analogCtl.currentToCompB <= 1'b0;
		end
		else
		begin
			analogCtl.currentToCompB <= delayMode; // [R08] [R09]
		end
	end

	// generated level becomes the trip point on comparator A
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			analogCtl.refToCompA <= 1'b0;
		end
		else
		begin
			analogCtl.refToCompA <= delayMode; // [R09]
		end
	end

	// grounding follows its bit even with the unit off, so the capacitor can be drained first
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			analogCtl.currentGround <= 1'b0;
		end
		else
		begin
			analogCtl.currentGround <= edgCtl[ETPU_IGND]; // [R14]
		end
	end

	// measurement pulse: high between the first and second event
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			analogCtl.measurePulse <= 1'b0;
		end
		else
		begin
			analogCtl.measurePulse <= active && edgCtl[ETPU_EDGE_PASS] && !edgCtl[ETPU_DLY_EN]
				&& next_e1Seen && !next_e2Seen; // [R11]
		end
	end

	// trigger marks completion of the measured interval
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			triggerOut <= 1'b0;
		end
		else
		begin
			triggerOut <= active && edgCtl[ETPU_TRIG] && e2Accept; // [R15]
		end
	end

	// the ladder itself is analog; these bits steer it and the level equation is applied there
	assign refSetting.genOn = refCtl[ETPU_REF_ON]; // [R01]
	assign refSetting.pinDrive = refCtl[ETPU_REF_ON] && refCtl[ETPU_REF_PIN]; // [R02]
	assign refSetting.rangeSelect = refCtl[ETPU_REF_RANGE]; // [R03]
	assign refSetting.spanSource = refCtl[ETPU_REF_SRC]; // [R04]
	assign refSetting.levelCode = refCtl[ETPU_REF_CODE_LSB +: 4]; // [R05]

endmodule : etpu_unit

// ==== verif/etpu_checker.sv ====
// port assertions for the edge timing pulse unit
`timescale 1ns/1ps
module etpu_checker (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire etpu_pkg::etpu_ref_t refSetting,
	input wire etpu_pkg::etpu_analog_t analogCtl,
	input wire logic delayedPulsePin,
	input wire logic triggerOut
);
	import etpu_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	err_unmapped_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && wb_adr_i != ETPU_ADDR_REFCTL
		&& wb_adr_i != ETPU_ADDR_EDGCTL |=> wb_err_o && !wb_ack_o) else $error("no err");
	upper_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ETPU_ADDR_REFCTL |-> wb_dat_o[31:8] == 0)
		else $error("upper bits set");
	pin_gate_a: assert property (refSetting.pinDrive |-> refSetting.genOn) else $error("pin without gen");
	ref_field_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == ETPU_ADDR_REFCTL && wb_sel_i[0]
		|-> refSetting.levelCode == wb_dat_i[3:0] && refSetting.genOn == wb_dat_i[7]
		&& refSetting.pinDrive == (wb_dat_i[7] && wb_dat_i[6]) && refSetting.rangeSelect == wb_dat_i[5]
		&& refSetting.spanSource == wb_dat_i[4]) else $error("ref field");
	ground_follow_a: assert property (wb_ack_o && wb_we_i && wb_adr_i == ETPU_ADDR_EDGCTL && wb_sel_i[1]
		|=> analogCtl.currentGround == $past(wb_dat_i[9])) else $error("ground bit");
	trig_once_a: assert property (triggerOut |=> !triggerOut) else $error("trigger long");
	pulse_once_a: assert property (delayedPulsePin |=> !delayedPulsePin) else $error("pulse long");
endmodule : etpu_checker
bind etpu_unit etpu_checker u_chk (.clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .refSetting, .analogCtl, .delayedPulsePin, .triggerOut);

// ==== verif/etpu_partner.sv ====
// far side model: edge sources and delay capacitor on comparator two
`timescale 1ns/1ps
module etpu_partner (
	input wire logic clk,
	input wire etpu_pkg::etpu_analog_t ctl,
	input wire logic [3:0] lvl,
	output etpu_pkg::etpu_edges_t edges,
	output logic comp
);
	import etpu_pkg::*;
	logic [4:0] chg = 5'h00;
	// struct bit index equals the source code, so the bench picks a source by index
	assign edges = lvl;
	// trips after 16 cycles of charge and stays high until grounded, as a real capacitor would
	assign comp = chg[4];
	always @(posedge clk)
		if (ctl.currentGround)
			chg <= 5'h00;
		else if (ctl.currentToCompB && !comp)
			chg <= chg + 5'h01;
endmodule : etpu_partner

// ==== verif/etpu_unit_tb.sv ====
// self-checking bench for the edge timing pulse unit
`timescale 1ns/1ps
module etpu_unit_tb;
	import etpu_pkg::*;
	logic clk = 0, arst_n = 0, cyc = 0, stb = 0, we = 0, idle = 0, comp, ack, err, dPin, trig, tS = 0, pS = 0;
	logic [3:0] adr = 4'h0, sel = 4'h0, lvl = 4'h0, bs = 4'h3;
	logic [31:0] dat = 32'h0, datO;
	etpu_edges_t edges;
	etpu_ref_t refS;
	etpu_analog_t ana;
	int n_errors = 0, checks = 0;
	always #25 clk = ~clk;
	etpu_unit u_dut (.clk, .arst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack), .wb_err_o(err), .deviceIdle(idle), .edgesIn(edges),
		.compTwoOut(comp), .refSetting(refS), .analogCtl(ana), .delayedPulsePin(dPin), .triggerOut(trig));
	etpu_partner u_far (.clk, .ctl(ana), .lvl, .edges, .comp);
	always @(posedge clk)
	begin
		if (trig === 1'h1) tS <= 1'h1;
		if (dPin === 1'h1) pS <= 1'h1;
	end
	task chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task bus(input logic w, input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
		cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; sel <= bs; dat <= {16'h0000, d};
		// ack or err ends this wait; if neither comes, only the watchdog ends it
		do @(posedge clk); while (ack !== 1'h1 && err !== 1'h1);
		q = datO[15:0];
		cyc <= 1'h0; stb <= 1'h0;
		@(posedge clk);
	endtask : bus
	task wr(input logic [3:0] a, input logic [15:0] d);
		logic [15:0] q;
		bus(1'h1, a, d, q);
	endtask : wr
	task rd(input logic [3:0] a, input logic [15:0] e);
		logic [15:0] q;
		bus(1'h0, a, 16'h0000, q);
		chk(q, e);
	endtask : rd
	// edges must stand two clocks; six covers sync, compare and status update
	task hold(input logic [3:0] v);
		lvl <= v;
		repeat (6) @(posedge clk);
	endtask : hold
	task t_regs;
		rd(4'h0, 16'h0000);
		rd(4'h4, 16'h0000);
		wr(4'h4, 16'hFFFF);
		rd(4'h4, 16'hBFFF);
		bs = 4'h1;
		wr(4'h4, 16'h0000);
		bs = 4'h3;
		rd(4'h4, 16'hBF00);
		rd(4'h8, 16'h0000);
		wr(4'h4, 16'h0000);
	endtask : t_regs
	task t_ref;
		wr(4'h0, 16'h007A);
		chk(refS, 16'h003A);
		wr(4'h0, 16'hFFFF);
		rd(4'h0, 16'h00FF);
		chk(refS, 16'h00FF);
	endtask : t_ref
	task t_reset;
		wr(4'h0, 16'h00FF);
		wr(4'h4, 16'h8803);
		arst_n <= 1'h0;
		repeat (2) @(posedge clk);
		chk(refS, 16'h0000);
		chk(ana, 16'h0000);
		arst_n <= 1'h1;
		@(posedge clk);
		rd(4'h0, 16'h0000);
		rd(4'h4, 16'h0000);
	endtask : t_reset
	task t_src;
		logic [15:0] v;
		for (int k = 0; k < 4; k++)
		begin
			v = 16'h8890 | 16'(k * 36);
			wr(4'h4, v);
			hold(4'h1 << k);
			rd(4'h4, v | 16'h0003);
			hold(4'h0);
		end
	endtask : t_src
	task t_pol;
		wr(4'h4, 16'h880C);
		hold(4'h8);
		rd(4'h4, 16'h880C);
		hold(4'h0);
		rd(4'h4, 16'h880D);
		wr(4'h4, 16'h8840);
		hold(4'h4);
		rd(4'h4, 16'h8840);
		hold(4'h0);
		rd(4'h4, 16'h8842);
	endtask : t_pol
	task t_gate;
		logic [15:0] cs [4] = '{16'h181C, 16'h901C, 16'hB81C, 16'h881C};
		idle <= 1'h1;
		pS <= 1'h0;
		for (int k = 0; k < 4; k++)
		begin
			wr(4'h4, cs[k]);
			hold(4'h8);
			rd(4'h4, cs[k] | 16'(k == 3));
			hold(4'h0);
		end
		chk(pS, 16'h0000);
		idle <= 1'h0;
	endtask : t_gate
	task t_order;
		wr(4'h4, 16'h8DDC);
		tS <= 1'h0;
		hold(4'h4);
		rd(4'h4, 16'h8DDC);
		chk(tS, 16'h0000);
		hold(4'hC);
		rd(4'h4, 16'h8DDD);
		chk(ana.measurePulse, 16'h0001);
		hold(4'h8);
		hold(4'hC);
		rd(4'h4, 16'h8DDF);
		chk(tS, 16'h0001);
		chk(ana.measurePulse, 16'h0000);
		hold(4'h0);
	endtask : t_order
	task t_delay;
		for (int k = 0; k < 2; k++)
		begin
			wr(4'h4, 16'h8A1C);
			chk(ana.currentGround, 16'h0001);
			wr(4'h4, k ? 16'h881C : 16'h981C);
			if (k == 0) chk(ana.refToCompA, 16'h0001);
			pS <= 1'h0;
			hold(4'h8);
			repeat (40) @(posedge clk);
			chk(pS, 16'(k == 0));
			hold(4'h0);
		end
	endtask : t_delay
	task results;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results
	initial
	begin
		#200us;
		n_errors++;
		results;
	end
	initial
	begin
		repeat (12) @(posedge clk);
		arst_n <= 1'h1;
		@(posedge clk);
		t_regs;
		t_ref;
		t_reset;
		t_src;
		t_pol;
		t_gate;
		t_order;
		t_delay;
		results;
	end
endmodule : etpu_unit_tb
